/* src/tsf_map.vh */
// constants for the transceiver status flag block
`ifndef TSF_MAP_VH
`define TSF_MAP_VH

// status word layout
`define TSF_WORD_W        13
`define TSF_IDX_W         4
`define TSF_WORD_RESET    13'h0000
`define TSF_S0_LOCAL_WAKE 0
`define TSF_S1_REMOTE_WAKE 1
`define TSF_S2_NODE_CFG   2
`define TSF_S3_POWER_UP   3
`define TSF_S4_BUS_ERR    4
`define TSF_S5_TEMP_HIGH  5
`define TSF_S6_TEMP_MED   6
`define TSF_S7_EN_STUCK   7
`define TSF_S8_UV_BAT     8
`define TSF_S9_UV_CORE    9
`define TSF_S10_UV_IO     10
`define TSF_LAST_IDX      4'hC

// sticky bits S3..S12 and readout-clearable bits S4..S12
`define TSF_STICKY_MASK   13'h1FF8
`define TSF_CLEARABLE_MASK 13'h1FF0

// clock period and filter times in ns
`define TSF_CLK_NS        5
`define TSF_T_DET_UV_CORE_NS 10000
`define TSF_T_REC_UV_CORE_NS 100000
`define TSF_T_DET_UV_IO_NS   10000
`define TSF_T_DET_COL_NS     1000
`define TSF_T_DET_EN_NS      100000

// filter counter width
`define TSF_CNT_W         20

`endif

/* src/tsf_filter.v */
// level filter with separate set and clear qualification times
`timescale 1ns/1ps

module tsf_filter #(
  parameter [19:0] SET_CYC = 20'h00001,
  parameter [19:0] CLR_CYC = 20'h00001
) (
  input  wire ref_clk,
  input  wire rst,
  input  wire raw_in,
  input  wire force_clr,
  output wire flag_out
);

  reg        flag_r;
  reg        armed_r;
  reg [19:0] cnt_r;
  reg [19:0] cnt_nxt;
  reg        flag_nxt;
  reg        armed_nxt;

  // ----------------------------------------------------------------
  // qualification counter
  // ----------------------------------------------------------------
  always @* begin
    cnt_nxt   = 20'h00000;
    flag_nxt  = flag_r;
    armed_nxt = armed_r | ~raw_in;
    if (force_clr) begin
      // a forced clear holds until the raw level has gone inactive once
      flag_nxt  = 1'b0;
      armed_nxt = 1'b0;
    end else if (raw_in != flag_r && (flag_r || armed_r)) begin
      if (cnt_r + 20'h00001 >= (flag_r ? CLR_CYC : SET_CYC)) begin
        flag_nxt = raw_in;
      end else begin
        cnt_nxt = cnt_r + 20'h00001;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      flag_r  <= 1'b0;
      armed_r <= 1'b1;
      cnt_r   <= 20'h00000;
    end else begin
      flag_r  <= flag_nxt;
      armed_r <= armed_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign flag_out = flag_r;

endmodule // tsf_filter

/* src/tsf_status.v */
// diagnostic flags and serial status readout of the bus transceiver
// Operation
// - bus error sets when transmitting enabled and bus data differs from transmit data
// - in star configuration bus error also sets on bus versus branch data mismatch
// - no bus error while a valid communication element is sent
// - bus error clears on data match or when transmitter is disabled
// - bus error flag is informational only, no action taken
// - battery undervoltage follows comparator, cleared by wake flag
// - core undervoltage uses detect filter and recovery time, cleared by wake
// - io undervoltage uses detect filter, clears at once or by wake
// - summary error flag is OR of status bits S4 to S12
// - star collision when both branch lines low beyond detection time
// - host shifts status out on error output using enable as clock
// - readout allowed only under the two supply conditions
// - after enable idle time, clear S4 to S12 whose flags are reset
// - error output low for a set bit, high for a clear one
// - S0 carries live local wake source flag
// - S2 carries live node configuration flag
// - flags S3 to S10 latch into sticky status bits
// - S1 carries live remote wake source flag
`timescale 1ns/1ps
`include "tsf_map.vh"

module tsf_status #(
  parameter T_DET_UV_CORE_NS = `TSF_T_DET_UV_CORE_NS,
  parameter T_REC_UV_CORE_NS = `TSF_T_REC_UV_CORE_NS,
  parameter T_DET_UV_IO_NS   = `TSF_T_DET_UV_IO_NS,
  parameter T_DET_COL_NS     = `TSF_T_DET_COL_NS,
  parameter T_DET_EN_NS      = `TSF_T_DET_EN_NS
) (
  input  wire        ref_clk,
  input  wire        rst,
  // pins, asynchronous to ref_clk
  input  wire        transmit_enable_input_n,
  input  wire        bus_guardian_enable_input,
  input  wire        bus_plus_line,
  input  wire        bus_minus_line,
  input  wire        tx_data_input,
  input  wire        star_branch_line_zero,
  input  wire        star_branch_line_one,
  input  wire        mode_enable_input,
  input  wire        battery_below_thr,
  input  wire        core_below_thr,
  input  wire        io_below_thr,
  input  wire        io_range_high,
  input  wire        io_range_low,
  // device logic on ref_clk
  input  wire        valid_element_tx,
  input  wire        wake_flag,
  input  wire        local_wake_source_bit,
  input  wire        remote_wake_source_bit,
  input  wire        node_config_flag,
  input  wire        power_up_flag,
  input  wire        temp_high_flag,
  input  wire        temp_medium_flag,
  input  wire        enable_stuck_bit,
  // outputs
  output wire        error_status_output_n,
  output wire        summary_error_flag,
  output wire        bus_error_flag,
  output wire        battery_undervoltage_flag,
  output wire        core_supply_undervoltage_flag,
  output wire        io_supply_undervoltage_flag,
  output wire        branch_collision,
  output wire        readout_active,
  output wire [12:0] transceiver_status_word
);

  // ----------------------------------------------------------------
  // derived cycle counts (least times round up)
  // ----------------------------------------------------------------
  localparam integer DET_UV_CORE_CYC = (T_DET_UV_CORE_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS;
  localparam integer REC_UV_CORE_CYC = (T_REC_UV_CORE_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS;
  localparam integer DET_UV_IO_CYC   = (T_DET_UV_IO_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS;
  localparam integer DET_COL_CYC     = (T_DET_COL_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS;
  localparam integer DET_EN_CYC      = (T_DET_EN_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS;

  // readout states, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_READ = 2'b10;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam PIN_W = 13;
  reg  [PIN_W-1:0] pin_meta_r;
  reg  [PIN_W-1:0] pin_sync_r;
  wire [PIN_W-1:0] pin_raw;

  assign pin_raw = {io_range_low, io_range_high, io_below_thr, core_below_thr,
                    battery_below_thr, mode_enable_input, star_branch_line_one,
                    star_branch_line_zero, tx_data_input, bus_minus_line,
                    bus_plus_line, bus_guardian_enable_input,
                    transmit_enable_input_n};

  always @(posedge ref_clk) begin
    if (rst) begin
      pin_meta_r <= 13'h0001;
      pin_sync_r <= 13'h0001;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  wire transmit_enable_input_n_s  = pin_sync_r[0];
  wire bge_s     = pin_sync_r[1];
  wire bp_s      = pin_sync_r[2];
  wire bm_s      = pin_sync_r[3];
  wire txd_s     = pin_sync_r[4];
  wire br0_s     = pin_sync_r[5];
  wire br1_s     = pin_sync_r[6];
  wire en_s      = pin_sync_r[7];
  wire bat_low_s = pin_sync_r[8];
  wire cor_low_s = pin_sync_r[9];
  wire io_low_s  = pin_sync_r[10];
  wire io_hi_s   = pin_sync_r[11];
  wire io_lo_s   = pin_sync_r[12];

  // ----------------------------------------------------------------
  // bus error flag
  // ----------------------------------------------------------------
  wire bus_data    = bp_s & ~bm_s;
  wire branch_data = br0_s & br1_s;
  wire tx_active   = ~transmit_enable_input_n_s & bge_s;
  reg  bus_err_r;
  reg  bus_err_nxt;

  always @* begin
    bus_err_nxt = bus_err_r;
    if (!tx_active || bus_data == txd_s) begin
      bus_err_nxt = 1'b0;
    end
    if (tx_active && bus_data != txd_s && !valid_element_tx) begin
      bus_err_nxt = 1'b1;
    end
    if (!node_config_flag && bus_data != branch_data && !valid_element_tx) begin
      bus_err_nxt = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      bus_err_r <= 1'b0;
    end else begin
      bus_err_r <= bus_err_nxt;
    end
  end

  assign bus_error_flag = bus_err_r;

  // ----------------------------------------------------------------
  // supply undervoltage flags and collision
  // ----------------------------------------------------------------
  reg  wake_d_r;
  wire wake_rise = wake_flag & ~wake_d_r;

  tsf_filter #(
    .SET_CYC (20'h00001),
    .CLR_CYC (20'h00001)
  ) u_uv_bat (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .raw_in    (bat_low_s),
    .force_clr (wake_rise),
    .flag_out  (battery_undervoltage_flag)
  );

  tsf_filter #(
    .SET_CYC (DET_UV_CORE_CYC[19:0]),
    .CLR_CYC (REC_UV_CORE_CYC[19:0])
  ) u_uv_core (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .raw_in    (cor_low_s),
    .force_clr (wake_rise),
    .flag_out  (core_supply_undervoltage_flag)
  );

  tsf_filter #(
    .SET_CYC (DET_UV_IO_CYC[19:0]),
    .CLR_CYC (20'h00001)
  ) u_uv_io (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .raw_in    (io_low_s),
    .force_clr (wake_rise),
    .flag_out  (io_supply_undervoltage_flag)
  );

  tsf_filter #(
    .SET_CYC (DET_COL_CYC[19:0]),
    .CLR_CYC (20'h00001)
  ) u_col (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .raw_in    (~node_config_flag & ~br0_s & ~br1_s),
    .force_clr (1'b0),
    .flag_out  (branch_collision)
  );

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  reg  [12:0] sticky_r;
  reg  [12:0] sticky_nxt;
  wire [12:0] flag_vec;
  wire [12:0] status_word;
  wire        idle_expire;

  assign flag_vec = {2'b00,
                     io_supply_undervoltage_flag,
                     core_supply_undervoltage_flag,
                     battery_undervoltage_flag,
                     enable_stuck_bit,
                     temp_medium_flag,
                     temp_high_flag,
                     bus_err_r,
                     power_up_flag,
                     3'b000} & `TSF_STICKY_MASK;

  always @* begin
    sticky_nxt = sticky_r;
    if (idle_expire) begin
      sticky_nxt = sticky_r & ~(`TSF_CLEARABLE_MASK & ~flag_vec);
    end
    sticky_nxt = sticky_nxt | flag_vec;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      sticky_r <= `TSF_WORD_RESET;
    end else begin
      sticky_r <= sticky_nxt;
    end
  end

  assign status_word = {sticky_r[12:3], node_config_flag,
                        remote_wake_source_bit, local_wake_source_bit};
  assign transceiver_status_word = status_word;

  assign summary_error_flag = |(status_word & `TSF_CLEARABLE_MASK);

  // ----------------------------------------------------------------
  // serial readout
  // ----------------------------------------------------------------
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [3:0]  idx_r;
  reg  [3:0]  idx_nxt;
  reg  [19:0] idle_cnt_r;
  reg  [19:0] idle_cnt_nxt;
  reg         en_d_r;
  reg         error_status_output_r;
  wire        en_edge = en_s & ~en_d_r;
  wire        access_ok = (~io_supply_undervoltage_flag & io_hi_s) |
                          (~core_supply_undervoltage_flag & io_lo_s);

  assign idle_expire = (state_r == ST_READ) && !en_edge &&
                       (idle_cnt_r + 20'h00001 >= DET_EN_CYC[19:0]);

  always @* begin
    state_nxt    = state_r;
    idx_nxt      = idx_r;
    idle_cnt_nxt = 20'h00000;
    case (state_r)
      ST_IDLE: begin
        if (en_edge && access_ok) begin
          state_nxt = ST_READ;
          idx_nxt   = 4'h0;
        end
      end
      ST_READ: begin
        if (en_edge) begin
          idx_nxt = (idx_r == `TSF_LAST_IDX) ? 4'h0 : idx_r + 4'h1;
        end else if (idle_expire) begin
          state_nxt = ST_IDLE;
          idx_nxt   = 4'h0;
        end else begin
          idle_cnt_nxt = idle_cnt_r + 20'h00001;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        idx_nxt   = 4'h0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      idx_r      <= 4'h0;
      idle_cnt_r <= 20'h00000;
      en_d_r     <= 1'b0;
      wake_d_r   <= 1'b0;
      error_status_output_r     <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      idx_r      <= idx_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      en_d_r     <= en_s;
      wake_d_r   <= wake_flag;
      if (state_nxt == ST_READ) begin
        error_status_output_r <= ~status_word[idx_nxt];
      end else begin
        error_status_output_r <= ~summary_error_flag;
      end
    end
  end

  assign error_status_output_n = error_status_output_r;
  assign readout_active        = (state_r == ST_READ);

endmodule // tsf_status

/* sim/tsf_status_monitor.sv */
// checker for flag timing and status readout
`timescale 1ns/1ps

module tsf_status_monitor (
  input wire        ref_clk,
  input wire        rst,
  input wire        transmit_enable_input_n,
  input wire        star_branch_line_zero,
  input wire        star_branch_line_one,
  input wire        core_below_thr,
  input wire        io_below_thr,
  input wire        valid_element_tx,
  input wire        local_wake_source_bit,
  input wire        remote_wake_source_bit,
  input wire        node_config_flag,
  input wire        error_status_output_n,
  input wire        summary_error_flag,
  input wire        bus_error_flag,
  input wire        core_supply_undervoltage_flag,
  input wire        io_supply_undervoltage_flag,
  input wire        branch_collision,
  input wire        readout_active,
  input wire [12:0] transceiver_status_word
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // --------------------------------------------------------------
  // flag and word relations
  // --------------------------------------------------------------
  chk_sum_or: assert property (summary_error_flag == |transceiver_status_word[12:4])
    else $error("summary flag wrong");
  chk_word_live: assert property (transceiver_status_word[2:0] ==
    {node_config_flag, remote_wake_source_bit, local_wake_source_bit})
    else $error("live bits wrong");
  chk_bus_disabled: assert property ((node_config_flag && transmit_enable_input_n)[*5]
    |-> !bus_error_flag) else $error("bus error kept while disabled");
  chk_valid_mask: assert property ($rose(bus_error_flag) |-> !$past(valid_element_tx))
    else $error("bus error during valid element");
  chk_bus_sticky: assert property (bus_error_flag |=> transceiver_status_word[4])
    else $error("bus error not latched");
  chk_io_filter: assert property ($rose(io_supply_undervoltage_flag)
    |-> $past(io_below_thr, 18)) else $error("io flag set too early");
  chk_core_filter: assert property ($rose(core_supply_undervoltage_flag)
    |-> $past(core_below_thr, 18)) else $error("core flag set too early");
  chk_col_time: assert property ($rose(branch_collision)
    |-> !($past(star_branch_line_zero, 18) | $past(star_branch_line_one, 18)))
    else $error("collision too early");
  chk_read_first: assert property ($rose(readout_active)
    |-> error_status_output_n == !transceiver_status_word[0]) else $error("first bit wrong");
  chk_idle_error_status_output: assert property (!readout_active && $past(!readout_active)
    && $stable(summary_error_flag) |-> error_status_output_n == !summary_error_flag)
    else $error("idle output wrong");

  cover property ($rose(readout_active));
  cover property ($rose(branch_collision));
  cover property ($fell(core_supply_undervoltage_flag));
endmodule // tsf_status_monitor

bind tsf_status tsf_status_monitor u_mon (.*);

/* sim/tsf_host_model.sv */
// host side model clocking the status word out
`timescale 1ns/1ps

module tsf_host_model (
  input  wire ref_clk,
  input  wire error_status_output_n,
  output reg  mode_enable_input
);
  initial mode_enable_input = 1'b0;

  task read_word(output reg [12:0] w);
    integer i;
    begin
      for (i = 0; i < 13; i = i + 1) begin
        repeat (16) @(posedge ref_clk);
        #1 mode_enable_input = 1'b1;
        repeat (16) @(posedge ref_clk);
        #1 w[i] = ~error_status_output_n;
        mode_enable_input = 1'b0;
      end
    end
  endtask
endmodule // tsf_host_model

/* sim/tsf_status_bench.sv */
// self-checking bench for the status flag block
`timescale 1ns/1ps

module tsf_status_bench;
  reg ref_clk = 1'b0, rst = 1'b1;
  reg transmit_enable_input_n = 1'b1, bus_guardian_enable_input = 1'b0;
  reg bus_plus_line = 1'b1, bus_minus_line = 1'b0, tx_data_input = 1'b1;
  reg star_branch_line_zero = 1'b1, star_branch_line_one = 1'b1;
  reg battery_below_thr = 1'b0, core_below_thr = 1'b0, io_below_thr = 1'b0;
  reg io_range_high = 1'b1, io_range_low = 1'b0, valid_element_tx = 1'b0;
  reg wake_flag = 1'b0, local_wake_source_bit = 1'b1, remote_wake_source_bit = 1'b0;
  reg node_config_flag = 1'b1, power_up_flag = 1'b0, temp_high_flag = 1'b0;
  reg temp_medium_flag = 1'b0, enable_stuck_bit = 1'b0;
  wire mode_enable_input, error_status_output_n, summary_error_flag, bus_error_flag;
  wire battery_undervoltage_flag, core_supply_undervoltage_flag, io_supply_undervoltage_flag;
  wire branch_collision, readout_active;
  wire [12:0] transceiver_status_word;
  reg [12:0] rd;
  integer num_errors = 0, n_compared = 0;

  always #2.5 ref_clk = ~ref_clk;

  tsf_status #(.T_DET_UV_CORE_NS(100), .T_REC_UV_CORE_NS(200), .T_DET_UV_IO_NS(100),
    .T_DET_COL_NS(100), .T_DET_EN_NS(500)) u_dut (.*);
  tsf_host_model u_host (.ref_clk(ref_clk), .error_status_output_n(error_status_output_n),
    .mode_enable_input(mode_enable_input));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task wt(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask

  task chk(input [12:0] got, input [12:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task chkb(input got, input exp);
    begin
      chk({12'h000, got}, {12'h000, exp});
    end
  endtask

  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask

  initial begin
    #100000;
    num_errors = num_errors + 1;
    test_done;
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    wt(6);
    rst = 1'b0;
    wt(4);
    chk(transceiver_status_word, 13'h0005);
    chkb(error_status_output_n, 1'b1);
    $display("test reset done");
    transmit_enable_input_n = 1'b0;
    bus_guardian_enable_input = 1'b1;
    bus_plus_line = 1'b0;
    wt(6);
    chkb(bus_error_flag, 1'b1);
    chkb(summary_error_flag, 1'b1);
    bus_plus_line = 1'b1;
    wt(6);
    chkb(bus_error_flag, 1'b0);
    chkb(transceiver_status_word[4], 1'b1);
    valid_element_tx = 1'b1;
    bus_plus_line = 1'b0;
    wt(6);
    chkb(bus_error_flag, 1'b0);
    bus_plus_line = 1'b1;
    wt(4);
    valid_element_tx = 1'b0;
    $display("test bus error done");
    node_config_flag = 1'b0;
    star_branch_line_zero = 1'b0;
    wt(6);
    chkb(bus_error_flag, 1'b1);
    star_branch_line_one = 1'b0;
    wt(30);
    chkb(branch_collision, 1'b1);
    star_branch_line_zero = 1'b1;
    star_branch_line_one = 1'b1;
    node_config_flag = 1'b1;
    transmit_enable_input_n = 1'b1;
    bus_guardian_enable_input = 1'b0;
    wt(8);
    chkb(bus_error_flag, 1'b0);
    $display("test star done");
    battery_below_thr = 1'b1;
    core_below_thr = 1'b1;
    io_below_thr = 1'b1;
    wt(10);
    chkb(battery_undervoltage_flag, 1'b1);
    chkb(core_supply_undervoltage_flag, 1'b0);
    chkb(io_supply_undervoltage_flag, 1'b0);
    wt(20);
    chkb(core_supply_undervoltage_flag, 1'b1);
    chkb(io_supply_undervoltage_flag, 1'b1);
    core_below_thr = 1'b0;
    io_below_thr = 1'b0;
    wt(6);
    chkb(io_supply_undervoltage_flag, 1'b0);
    chkb(core_supply_undervoltage_flag, 1'b1);
    wt(45);
    chkb(core_supply_undervoltage_flag, 1'b0);
    wake_flag = 1'b1;
    wt(3);
    chkb(battery_undervoltage_flag, 1'b0);
    wake_flag = 1'b0;
    battery_below_thr = 1'b0;
    $display("test supply done");
    power_up_flag = 1'b1;
    temp_medium_flag = 1'b1;
    enable_stuck_bit = 1'b1;
    wt(2);
    power_up_flag = 1'b0;
    temp_medium_flag = 1'b0;
    enable_stuck_bit = 1'b0;
    wt(2);
    u_host.read_word(rd);
    chk(rd, 13'h07DD);
    wt(130);
    chk(transceiver_status_word, 13'h000D);
    chkb(error_status_output_n, 1'b1);
    $display("test readout done");
    io_range_high = 1'b0;
    wt(4);
    u_host.read_word(rd);
    chk(rd, 13'h0000);
    chkb(readout_active, 1'b0);
    $display("test refused done");
    io_range_low = 1'b1;
    remote_wake_source_bit = 1'b1;
    temp_high_flag = 1'b1;
    wt(2);
    temp_high_flag = 1'b0;
    wt(4);
    u_host.read_word(rd);
    chk(rd, 13'h002F);
    chkb(readout_active, 1'b1);
    $display("test low range done");
    test_done;
  end
endmodule // tsf_status_bench
